// *** logic/mfd_pkg.sv ***
// Constants and types of the request function dispatcher
package mfd_pkg;

	// **********************************************************
	// Function codes
	// **********************************************************
	localparam logic [7:0] MFD_FC_RD_COILS  = 8'h01;
	localparam logic [7:0] MFD_FC_RD_DISC   = 8'h02;
	localparam logic [7:0] MFD_FC_RD_HOLD   = 8'h03;
	localparam logic [7:0] MFD_FC_RD_INPUT  = 8'h04;
	localparam logic [7:0] MFD_FC_WR_COIL   = 8'h05;
	localparam logic [7:0] MFD_FC_WR_REG    = 8'h06;
	localparam logic [7:0] MFD_FC_DIAG      = 8'h08;
	localparam logic [7:0] MFD_FC_WR_COILS  = 8'h0f;
	localparam logic [7:0] MFD_FC_WR_REGS   = 8'h10;
	localparam logic [7:0] MFD_FC_TRANSPORT = 8'h2b;
	localparam logic [7:0] MFD_FC_EXC_FLAG  = 8'h80;

	// **********************************************************
	// Sub-functions and exception codes
	// **********************************************************
	localparam logic [15:0] MFD_DIAG_ECHO   = 16'h0000;
	localparam logic [15:0] MFD_XPORT_CFG_A = 16'h0060;
	localparam logic [15:0] MFD_XPORT_CFG_B = 16'h0081;
	localparam logic [7:0]  MFD_EXC_FUNC    = 8'h01;
	localparam logic [7:0]  MFD_EXC_ADDR    = 8'h02;
	localparam logic [7:0]  MFD_EXC_VALUE   = 8'h03;

	// **********************************************************
	// Register ranges (first and last number, decimal in comment)
	// **********************************************************
	localparam logic [15:0] MFD_DISC_LO  = 16'h03e9; // 1001
	localparam logic [15:0] MFD_DISC_HI  = 16'h07cf; // 1999
	localparam logic [15:0] MFD_COIL_LO  = 16'h07d1; // 2001
	localparam logic [15:0] MFD_COIL_HI  = 16'h0bb7; // 2999
	localparam logic [15:0] MFD_HOLD_LO  = 16'h0bb9; // 3001
	localparam logic [15:0] MFD_HOLD_HI  = 16'h0f9f; // 3999
	localparam logic [15:0] MFD_INPUT_LO = 16'h0fa1; // 4001
	localparam logic [15:0] MFD_INPUT_HI = 16'h1387; // 4999
	localparam logic [15:0] MFD_LONG_LO  = 16'h1f41; // 8001
	localparam logic [15:0] MFD_LONG_HI  = 16'h2133; // 8499
	localparam logic [15:0] MFD_FLT_LO   = 16'h2329; // 9001
	localparam logic [15:0] MFD_FLT_HI   = 16'h270f; // 9999
	localparam logic [15:0] MFD_LONG_ALT = 16'h1389; // 5001
	localparam logic [15:0] MFD_FLT_ALT  = 16'h1771; // 6001

	// **********************************************************
	// Network timing
	// **********************************************************
	localparam int MFD_CLK_HZ        = 200_000_000;
	localparam int MFD_DHCP_RETRY_MS = 1000;
	localparam int MFD_DHCP_RETRY_CYC =
		MFD_DHCP_RETRY_MS * (MFD_CLK_HZ / 1000);

	// **********************************************************
	// Types
	// **********************************************************
	typedef enum logic [2:0] {
		MFD_SP_NONE  = 3'b000,
		MFD_SP_COIL  = 3'b001,
		MFD_SP_DISC  = 3'b010,
		MFD_SP_HOLD  = 3'b011,
		MFD_SP_INPUT = 3'b100,
		MFD_SP_DIAG  = 3'b101,
		MFD_SP_FILE  = 3'b110
	} mfd_space_t;

	typedef enum logic [1:0] {
		MFD_NET_IDLE  = 2'b00,
		MFD_NET_REQ   = 2'b01,
		MFD_NET_WAIT  = 2'b10,
		MFD_NET_BOUND = 2'b11
	} mfd_net_t;

endpackage

// *** logic/mfd_pair_map.sv ***
// Two-word register number translation to the alternate scheme
`timescale 1ns/1ps
module mfd_pair_map
	import mfd_pkg::*;
(
	input  wire logic [15:0] addr_i,
	input  wire logic [15:0] qty_i,
	output logic      [15:0] map_addr_o,
	output logic      [15:0] map_qty_o,
	output logic             long_o,
	output logic             float_o
);

	logic [15:0] off;

	// **********************************************************
	// Translation
	// **********************************************************
	always_comb begin
		off        = 16'h0000;
		map_addr_o = addr_i;
		map_qty_o  = qty_i;
		long_o     = (addr_i >= MFD_LONG_LO) && (addr_i <= MFD_LONG_HI);
		float_o    = (addr_i >= MFD_FLT_LO) && (addr_i <= MFD_FLT_HI);
		// Each value fills a pair of words, so count and offset double
		if (long_o) begin
			off        = addr_i - MFD_LONG_LO;
			map_addr_o = MFD_LONG_ALT + {off[14:0], 1'b0};
			map_qty_o  = {qty_i[14:0], 1'b0};
		end else if (float_o) begin
			off        = addr_i - MFD_FLT_LO;
			map_addr_o = MFD_FLT_ALT + {off[14:0], 1'b0};
			map_qty_o  = {qty_i[14:0], 1'b0};
		end
	end

endmodule

// *** logic/mfd_dispatch.sv ***
// Request function dispatcher with network address bring-up
`timescale 1ns/1ps
module mfd_dispatch
	import mfd_pkg::*;
#(
	parameter int DHCP_RETRY_CYC = MFD_DHCP_RETRY_CYC
)
(
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic        req_valid_i,
	input  wire logic [7:0]  req_func_i,
	input  wire logic [15:0] req_sub_i,
	input  wire logic [15:0] req_addr_i,
	input  wire logic [15:0] req_qty_i,
	input  wire logic [15:0] req_data_i,
	input  wire logic        link_up_i,
	input  wire logic        static_ip_i,
	input  wire logic        dhcp_ack_i,
	output logic             rsp_valid_o,
	output logic             rsp_ok_o,
	output logic [7:0]       rsp_func_o,
	output logic [7:0]       rsp_exc_o,
	output logic [2:0]       rsp_space_o,
	output logic [15:0]      rsp_addr_o,
	output logic [15:0]      rsp_qty_o,
	output logic [15:0]      rsp_data_o,
	output logic             rsp_wide_o,
	output logic             dhcp_req_o,
	output logic             net_ready_o
);

	// **********************************************************
	// State
	// **********************************************************
	typedef struct packed {
		logic        rsp_valid;
		logic        rsp_ok;
		logic [7:0]  rsp_func;
		logic [7:0]  rsp_exc;
		mfd_space_t  rsp_space;
		logic [15:0] rsp_addr;
		logic [15:0] rsp_qty;
		logic [15:0] rsp_data;
		logic        rsp_wide;
		mfd_net_t    net_st;
		logic        dhcp_req;
		logic        net_ready;
		logic [31:0] retry_cnt;
	} mfd_state_t;

	localparam logic [31:0] RETRY_LAST = 32'(DHCP_RETRY_CYC - 1);

	mfd_state_t  st_r;
	mfd_state_t  st_nxt;
	logic [15:0] map_addr;
	logic [15:0] map_qty;
	logic        is_long;
	logic        is_float;

	mfd_pair_map u_map (
		.addr_i     (req_addr_i),
		.qty_i      (req_qty_i),
		.map_addr_o (map_addr),
		.map_qty_o  (map_qty),
		.long_o     (is_long),
		.float_o    (is_float)
	);

	function automatic logic fits(input logic [15:0] lo,
	                              input logic [15:0] hi,
	                              input logic [15:0] a,
	                              input logic [16:0] e);
		fits = (a >= lo) && (e <= {1'b0, hi});
	endfunction

	// **********************************************************
	// Next state
	// **********************************************************
	logic [16:0] last_multi;
	logic [16:0] last_one;
	logic        ok;
	logic        bad_qty;
	logic        wide;
	logic [7:0]  exc;
	mfd_space_t  space;

	always_comb begin
		st_nxt     = st_r;
		last_multi = {1'b0, req_addr_i} + {1'b0, req_qty_i} - 17'h00001;
		last_one   = {1'b0, req_addr_i};
		ok         = 1'b0;
		bad_qty    = 1'b0;
		wide       = 1'b0;
		exc        = MFD_EXC_ADDR;
		space      = MFD_SP_NONE;

		case (req_func_i)
		MFD_FC_RD_COILS, MFD_FC_WR_COILS: begin
			bad_qty = (req_qty_i == 16'h0000);
			ok = fits(MFD_COIL_LO, MFD_COIL_HI, req_addr_i,
			          last_multi);
			space = MFD_SP_COIL;
		end
		MFD_FC_WR_COIL: begin
			ok = fits(MFD_COIL_LO, MFD_COIL_HI, req_addr_i,
			          last_one);
			space = MFD_SP_COIL;
		end
		MFD_FC_RD_DISC: begin
			bad_qty = (req_qty_i == 16'h0000);
			ok = fits(MFD_DISC_LO, MFD_DISC_HI, req_addr_i,
			          last_multi);
			space = MFD_SP_DISC;
		end
		MFD_FC_RD_HOLD, MFD_FC_WR_REGS: begin
			bad_qty = (req_qty_i == 16'h0000);
			ok = fits(MFD_HOLD_LO, MFD_HOLD_HI, req_addr_i, last_multi)
			  || fits(MFD_LONG_LO, MFD_LONG_HI, req_addr_i, last_multi)
			  || fits(MFD_FLT_LO, MFD_FLT_HI, req_addr_i,
			          last_multi);
			space = MFD_SP_HOLD;
			wide  = is_long || is_float;
		end
		MFD_FC_RD_INPUT: begin
			bad_qty = (req_qty_i == 16'h0000);
			ok = fits(MFD_INPUT_LO, MFD_INPUT_HI, req_addr_i, last_multi)
			  || fits(MFD_LONG_LO, MFD_LONG_HI, req_addr_i, last_multi)
			  || fits(MFD_FLT_LO, MFD_FLT_HI, req_addr_i,
			          last_multi);
			space = MFD_SP_INPUT;
			wide  = is_long || is_float;
		end
		MFD_FC_WR_REG: begin
			// Half of a word pair can never be written alone
			ok = fits(MFD_HOLD_LO, MFD_HOLD_HI, req_addr_i,
			          last_one);
			space = MFD_SP_HOLD;
		end
		MFD_FC_DIAG: begin
			ok    = (req_sub_i == MFD_DIAG_ECHO);
			exc   = MFD_EXC_FUNC;
			space = MFD_SP_DIAG;
		end
		MFD_FC_TRANSPORT: begin
			ok    = (req_sub_i == MFD_XPORT_CFG_A)
			     || (req_sub_i == MFD_XPORT_CFG_B);
			exc   = MFD_EXC_FUNC;
			space = MFD_SP_FILE;
		end
		default: begin
			exc = MFD_EXC_FUNC;
		end
		endcase

		if (bad_qty) begin
			ok  = 1'b0;
			exc = MFD_EXC_VALUE;
		end

		st_nxt.rsp_valid = req_valid_i;
		if (req_valid_i) begin
			st_nxt.rsp_ok    = ok;
			st_nxt.rsp_exc   = ok ? 8'h00 : exc;
			st_nxt.rsp_func  = ok ? req_func_i
			                      : (req_func_i | MFD_FC_EXC_FLAG);
			st_nxt.rsp_space = ok ? space : MFD_SP_NONE;
			st_nxt.rsp_wide  = ok && wide;
			// Pair doubling assumes the count is in whole values
			st_nxt.rsp_addr  = (ok && wide) ? map_addr : req_addr_i;
			st_nxt.rsp_qty   = (ok && wide) ? map_qty : req_qty_i;
			st_nxt.rsp_data  = req_data_i;
		end

		// Network bring-up; static mode skips address negotiation
		st_nxt.dhcp_req = 1'b0;
		case (st_r.net_st)
		MFD_NET_IDLE: begin
			st_nxt.net_ready = 1'b0;
			if (link_up_i) begin
				st_nxt.net_st = static_ip_i ? MFD_NET_BOUND
				                            : MFD_NET_REQ;
				st_nxt.net_ready = static_ip_i;
			end
		end
		MFD_NET_REQ: begin
			st_nxt.dhcp_req  = 1'b1;
			st_nxt.retry_cnt = 32'h00000000;
			st_nxt.net_st    = MFD_NET_WAIT;
		end
		MFD_NET_WAIT: begin
			if (dhcp_ack_i) begin
				st_nxt.net_st    = MFD_NET_BOUND;
				st_nxt.net_ready = 1'b1;
			end else if (st_r.retry_cnt == RETRY_LAST) begin
				st_nxt.net_st = MFD_NET_REQ;
			end else begin
				st_nxt.retry_cnt = st_r.retry_cnt + 32'h00000001;
			end
		end
		MFD_NET_BOUND: begin
			st_nxt.net_ready = 1'b1;
		end
		default: begin
			st_nxt.net_st = MFD_NET_IDLE;
		end
		endcase
		// Losing the link drops the lease; a new one is fetched later
		if (!link_up_i) begin
			st_nxt.net_st    = MFD_NET_IDLE;
			st_nxt.net_ready = 1'b0;
			st_nxt.dhcp_req  = 1'b0;
		end
	end

	// **********************************************************
	// Registers
	// **********************************************************
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			st_r           <= '0;
			st_r.rsp_space <= MFD_SP_NONE;
			st_r.net_st    <= MFD_NET_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rsp_valid_o = st_r.rsp_valid;
	assign rsp_ok_o    = st_r.rsp_ok;
	assign rsp_func_o  = st_r.rsp_func;
	assign rsp_exc_o   = st_r.rsp_exc;
	assign rsp_space_o = st_r.rsp_space;
	assign rsp_addr_o  = st_r.rsp_addr;
	assign rsp_qty_o   = st_r.rsp_qty;
	assign rsp_data_o  = st_r.rsp_data;
	assign rsp_wide_o  = st_r.rsp_wide;
	assign dhcp_req_o  = st_r.dhcp_req;
	assign net_ready_o = st_r.net_ready;

endmodule

// *** tb/mfd_dhcp_server.sv ***
// Address server stand-in that answers the port's requests
`timescale 1ns/1ps
module mfd_dhcp_server (
	input  wire logic       clk_i,
	input  wire logic       en_i,
	input  wire logic [3:0] dly_i,
	input  wire logic       req_i,
	output logic            ack_o
);
	logic [3:0] cnt_r;
	logic       busy_r;
	initial begin
		ack_o = 1'b0;
		busy_r = 1'b0;
		cnt_r = 4'h0;
	end
	// Acks only a seen request, promptly or dly_i + 1 cycles later
	always @(posedge clk_i) begin
		ack_o <= 1'b0;
		if (req_i && en_i && dly_i == 4'h0) begin
			ack_o <= 1'b1;
		end else if (req_i && en_i) begin
			busy_r <= 1'b1;
			cnt_r <= dly_i;
		end else if (busy_r && cnt_r == 4'h0) begin
			ack_o <= 1'b1;
			busy_r <= 1'b0;
		end else if (busy_r) begin
			cnt_r <= cnt_r - 4'h1;
		end
	end
endmodule

// *** tb/mfd_dispatch_asserts.sv ***
// Port checks of the request dispatcher
`timescale 1ns/1ps
module mfd_dispatch_asserts
	import mfd_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        nrst_i,
	input wire logic        req_valid_i,
	input wire logic [7:0]  req_func_i,
	input wire logic [15:0] req_sub_i,
	input wire logic [15:0] req_addr_i,
	input wire logic [15:0] req_qty_i,
	input wire logic [15:0] req_data_i,
	input wire logic        link_up_i,
	input wire logic        static_ip_i,
	input wire logic        dhcp_ack_i,
	input wire logic        rsp_valid_o,
	input wire logic        rsp_ok_o,
	input wire logic [7:0]  rsp_func_o,
	input wire logic [7:0]  rsp_exc_o,
	input wire logic [2:0]  rsp_space_o,
	input wire logic [15:0] rsp_addr_o,
	input wire logic [15:0] rsp_qty_o,
	input wire logic [15:0] rsp_data_o,
	input wire logic        rsp_wide_o,
	input wire logic        dhcp_req_o,
	input wire logic        net_ready_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	logic [16:0] disc_end;
	// Widened so a range running past 0xffff cannot wrap into range
	assign disc_end = {1'b0, req_addr_i} + {1'b0, req_qty_i} - 17'h1;
	sequence link_rise_s;
		$rose(link_up_i) && !static_ip_i;
	endsequence
	sequence dhcp_pulse_s;
		dhcp_req_o ##1 !dhcp_req_o;
	endsequence
	// ****
	// Requests
	// ****
	rsp_one_a: assert property (nrst_i && req_valid_i
		|=> rsp_valid_o && rsp_data_o == $past(req_data_i))
		else $error("no answer");
	rsp_idle_a: assert property (!req_valid_i |=> !rsp_valid_o)
		else $error("stray answer");
	exc_func_a: assert property (rsp_valid_o && !rsp_ok_o |->
		rsp_func_o == ($past(req_func_i) | MFD_FC_EXC_FLAG)
		&& rsp_space_o == 3'h0) else $error("bad exception");
	coil_only_a: assert property (req_valid_i
		&& req_func_i == MFD_FC_WR_COIL && (req_addr_i < MFD_COIL_LO
		|| req_addr_i > MFD_COIL_HI) |=> rsp_exc_o == MFD_EXC_ADDR)
		else $error("coil write out of range");
	disc_ok_a: assert property (req_valid_i
		&& req_func_i == MFD_FC_RD_DISC && req_qty_i != 16'h0
		&& req_addr_i >= MFD_DISC_LO && disc_end <= {1'b0, MFD_DISC_HI}
		|=> rsp_ok_o && rsp_space_o == 3'h2) else $error("discrete");
	wr_reg_a: assert property (req_valid_i
		&& req_func_i == MFD_FC_WR_REG && req_addr_i >= MFD_LONG_LO
		|=> rsp_exc_o == MFD_EXC_ADDR) else $error("wide single write");
	diag_sub_a: assert property (req_valid_i
		&& req_func_i == MFD_FC_DIAG |=>
		rsp_ok_o == ($past(req_sub_i) == MFD_DIAG_ECHO))
		else $error("diag sub");
	xport_sub_a: assert property (req_valid_i
		&& req_func_i == MFD_FC_TRANSPORT |=>
		rsp_ok_o == ($past(req_sub_i) == MFD_XPORT_CFG_A
		|| $past(req_sub_i) == MFD_XPORT_CFG_B)) else $error("xport");
	long_map_a: assert property (rsp_valid_o && rsp_wide_o
		&& $past(req_addr_i) <= MFD_LONG_HI |-> rsp_addr_o ==
		MFD_LONG_ALT + (($past(req_addr_i) - MFD_LONG_LO) << 1)
		&& rsp_qty_o == $past(req_qty_i) << 1) else $error("long map");
	// ****
	// Network port
	// ****
	dhcp_start_a: assert property (link_rise_s |-> ##2 dhcp_pulse_s)
		else $error("no address request");
	dhcp_done_a: assert property (link_up_i && dhcp_req_o
		##1 dhcp_ack_i |=> net_ready_o) else $error("not ready");
	ready_drop_a: assert property (net_ready_o && !link_up_i
		|=> !net_ready_o) else $error("ready after link loss");
	static_a: assert property (static_ip_i && $rose(link_up_i)
		|-> ##[1:2] net_ready_o) else $error("static not ready");
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench of the request dispatcher
`timescale 1ns/1ps
module tb_top
	import mfd_pkg::*;
;
	localparam int RETRY = 20;
	localparam int N = 22;
	typedef struct packed {
		logic [7:0]  f;
		logic [15:0] s;
		logic [15:0] a;
		logic [15:0] q;
		logic [7:0]  e;
		logic [2:0]  sp;
	} mfd_row_t;
	// Wide rows always ask whole pairs from the first or the last register of their range
	localparam mfd_row_t T [N] = '{
		'{8'h01, 16'h0, MFD_COIL_LO, 16'h1, 8'h0, 3'h1},
		'{8'h01, 16'h0, MFD_HOLD_LO, 16'h1, 8'h2, 3'h0},
		'{8'h05, 16'h0, MFD_COIL_HI, 16'h0, 8'h0, 3'h1},
		'{8'h05, 16'h0, MFD_HOLD_LO, 16'h0, 8'h2, 3'h0},
		'{8'h0f, 16'h0, MFD_COIL_HI, 16'h2, 8'h2, 3'h0},
		'{8'h02, 16'h0, MFD_DISC_LO, 16'h1, 8'h0, 3'h2},
		'{8'h02, 16'h0, MFD_COIL_LO, 16'h1, 8'h2, 3'h0},
		'{8'h03, 16'h0, MFD_HOLD_HI, 16'h1, 8'h0, 3'h3},
		'{8'h03, 16'h0, MFD_LONG_LO, 16'h2, 8'h0, 3'h3},
		'{8'h03, 16'h0, MFD_HOLD_LO, 16'h0, 8'h3, 3'h0},
		'{8'h10, 16'h0, MFD_FLT_LO, 16'h1, 8'h0, 3'h3},
		'{8'h04, 16'h0, MFD_INPUT_HI, 16'h1, 8'h0, 3'h4},
		'{8'h04, 16'h0, MFD_LONG_HI, 16'h1, 8'h0, 3'h4},
		'{8'h04, 16'h0, MFD_FLT_HI, 16'h1, 8'h0, 3'h4},
		'{8'h06, 16'h0, MFD_HOLD_LO, 16'h0, 8'h0, 3'h3},
		'{8'h06, 16'h0, MFD_LONG_LO, 16'h0, 8'h2, 3'h0},
		'{8'h08, 16'h0, 16'h0, 16'h0, 8'h0, 3'h5},
		'{8'h08, 16'h1, 16'h0, 16'h0, 8'h1, 3'h0},
		'{8'h2b, 16'h60, 16'h0, 16'h0, 8'h0, 3'h6},
		'{8'h2b, 16'h81, 16'h0, 16'h0, 8'h0, 3'h6},
		'{8'h2b, 16'h0e, 16'h0, 16'h0, 8'h1, 3'h0},
		'{8'h07, 16'h0, 16'h0, 16'h0, 8'h1, 3'h0}};
	logic        clk_i, nrst_i, req_valid_i, link_up_i, static_ip_i;
	logic        dhcp_ack_i, rsp_valid_o, rsp_ok_o, rsp_wide_o;
	logic        dhcp_req_o, net_ready_o, ack_en;
	logic [7:0]  req_func_i, rsp_func_o, rsp_exc_o;
	logic [15:0] req_sub_i, req_addr_i, req_qty_i, req_data_i;
	logic [15:0] rsp_addr_o, rsp_qty_o, rsp_data_o;
	logic [2:0]  rsp_space_o;
	logic [3:0]  dly;
	int          n_fail = 0, num_checks = 0, i, c;
	mfd_dispatch #(.DHCP_RETRY_CYC(RETRY)) DUT (.clk_i, .nrst_i,
		.req_valid_i, .req_func_i, .req_sub_i, .req_addr_i, .req_qty_i,
		.req_data_i, .link_up_i, .static_ip_i, .dhcp_ack_i, .rsp_valid_o,
		.rsp_ok_o, .rsp_func_o, .rsp_exc_o, .rsp_space_o, .rsp_addr_o,
		.rsp_qty_o, .rsp_data_o, .rsp_wide_o, .dhcp_req_o, .net_ready_o);
	mfd_dhcp_server u_srv (.clk_i, .en_i(ack_en), .dly_i(dly),
		.req_i(dhcp_req_o), .ack_o(dhcp_ack_i));
	task ck(input bit ok, input string m);
		num_checks++;
		if (!ok) begin
			n_fail++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Bounded wait; a miss shows up in the check that follows
	// Looks only after an edge has settled, never in the launching step
	task wait_sig(input bit rdy, input int lim, output int n);
		n = 0;
		do begin
			@(posedge clk_i);
			#1;
			n++;
		end while ((rdy ? net_ready_o : dhcp_req_o) !== 1'b1 && n < lim);
	endtask
	task check_row(input int k);
		mfd_row_t    r;
		bit          ok, w;
		logic [15:0] ea, eq;
		r = T[k];
		ok = r.e == 8'h0;
		w = ok && r.a >= MFD_LONG_LO;
		ea = r.a >= MFD_FLT_LO ? MFD_FLT_ALT + ((r.a - MFD_FLT_LO) << 1) :
			w ? MFD_LONG_ALT + ((r.a - MFD_LONG_LO) << 1) : r.a;
		eq = w ? r.q << 1 : r.q;
		ck(rsp_valid_o === 1'b1 && rsp_data_o === 16'(k + 1), "answer");
		ck(rsp_ok_o === ok && rsp_exc_o === r.e, "status");
		ck(rsp_func_o === (ok ? r.f : r.f | MFD_FC_EXC_FLAG), "func");
		ck(rsp_space_o === r.sp, "space");
		ck(rsp_wide_o === w, "wide");
		if (ok)
			ck(rsp_addr_o === ea && rsp_qty_o === eq && rsp_wide_o === w, "map");
	endtask
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	initial begin
		#20000;
		n_fail++;
		end_sim;
	end
	initial begin
		{nrst_i, req_valid_i, link_up_i, static_ip_i, ack_en} = 5'h0;
		{req_func_i, req_sub_i, req_addr_i, req_qty_i, req_data_i} = 72'h0;
		dly = 4'h0;
		repeat (8) @(posedge clk_i);
		#1 ck(rsp_valid_o === 1'b0 && net_ready_o === 1'b0, "reset");
		@(posedge clk_i) nrst_i <= 1'b1;
		// ****
		// Back-to-back table of requests
		// ****
		for (i = 0; i <= N; i++) begin
			@(posedge clk_i);
			req_valid_i <= i < N;
			if (i < N) begin
				req_func_i <= T[i].f;
				req_sub_i <= T[i].s;
				req_addr_i <= T[i].a;
				req_qty_i <= T[i].q;
				req_data_i <= 16'(i + 1);
			end
			#1;
			if (i > 0)
				check_row(i - 1);
		end
		// ****
		// Network bring-up, retry, slow server, static address
		// ****
		@(posedge clk_i) link_up_i <= 1'b1;
		wait_sig(1'b0, 10, c);
		ck(c == 2, "dhcp start");
		@(posedge clk_i) ack_en <= 1'b1;
		wait_sig(1'b0, RETRY + 10, c);
		ck(c >= RETRY && c <= RETRY + 4, "retry");
		wait_sig(1'b1, 6, c);
		ck(net_ready_o === 1'b1, "ready");
		@(posedge clk_i) link_up_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1 ck(net_ready_o === 1'b0, "link loss");
		dly <= 4'h4;
		@(posedge clk_i) link_up_i <= 1'b1;
		wait_sig(1'b1, 18, c);
		ck(net_ready_o === 1'b1 && c > 6, "slow server");
		@(posedge clk_i) link_up_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		static_ip_i <= 1'b1;
		link_up_i <= 1'b1;
		wait_sig(1'b1, 3, c);
		ck(net_ready_o === 1'b1 && c <= 2, "static");
		// ****
		// Reset in mid-run with a request pending
		// ****
		@(posedge clk_i) nrst_i <= 1'b0;
		req_valid_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1 ck(rsp_valid_o === 1'b0 && net_ready_o === 1'b0, "mid reset");
		@(posedge clk_i) nrst_i <= 1'b1;
		req_valid_i <= 1'b0;
		link_up_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		end_sim;
	end
endmodule
bind mfd_dispatch mfd_dispatch_asserts u_chk (.clk_i, .nrst_i,
	.req_valid_i, .req_func_i, .req_sub_i, .req_addr_i, .req_qty_i,
	.req_data_i, .link_up_i, .static_ip_i, .dhcp_ack_i, .rsp_valid_o,
	.rsp_ok_o, .rsp_func_o, .rsp_exc_o, .rsp_space_o, .rsp_addr_o,
	.rsp_qty_o, .rsp_data_o, .rsp_wide_o, .dhcp_req_o, .net_ready_o);
